// ==== ssa_slave.sv ====
// Management-bus slave port: address match, pointer, register writes and
// reads, alert response. Assumes a register file on mclk that answers the
// pointer combinationally on reg_rd_data, and a pull-up on the bus lines.
`timescale 1ns/100ps
`default_nettype none
// Function
// - Answer to address 01011 plus two low bits from the strap.
// - Strap ground gives 00, open gives 10, supply gives 01.
// - Strap is taken once after reset; later changes are ignored.
// - START begins a transfer; eight bits follow, address first, MSB first.
// - On own address drive SDA low for the ninth pulse, else idle.
// - Direction bit zero writes, one reads.
// - Each byte is eight data pulses plus one acknowledge pulse.
// - SDA moves only while SCL low; rise with SCL high is STOP.
// - Direction is fixed per transfer; new direction needs new START.
// - Writes carry one or two bytes, reads return one byte.
// - First write byte loads the address pointer.
// - Second write byte goes to the register the pointer selects.
// - A one-byte write changes only the pointer.
// - A read returns the register the current pointer selects.
// - Pointer write then repeated-start read returns one byte.
// - With alert active, answer the alert response address with own address.
// - Release alert after answering; monitoring may raise it again.
module ssa_slave
  import ssa_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [1:0] strap_state,
  input wire logic alert_event,
  output logic alert_oe,
  output logic [7:0] reg_ptr,
  output ssa_wr_type reg_wr,
  input wire logic [7:0] reg_rd_data
);

  function automatic logic [1:0] strap_low(input logic [1:0] s);
    unique case (s)
      STRAP_GND: strap_low = LOW_GND;
      STRAP_VCC: strap_low = LOW_VCC;
      default: strap_low = LOW_OPEN;
    endcase
  endfunction

  // Open-drain drive: high means pull SDA low in the current slot.
  function automatic logic drive_low(input ssa_state_type st,
                                     input logic tx_msb);
    unique case (st)
      ST_AACK, ST_WACK: drive_low = 1'b1;
      ST_RDATA: drive_low = ~tx_msb;
      default: drive_low = 1'b0;
    endcase
  endfunction

  logic link_bit;
  logic link_tog;
  logic scl_s, sda_s, tog_s;
  logic [1:0] strap_s;
  logic scl_p, sda_p, tog_p;
  logic start_evt, stop_evt, bit_evt, scl_fall;
  ssa_state_type state_q;
  logic [2:0] cnt_q;
  logic [1:0] wbyte_q;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic rw_q;
  logic ara_q;
  logic [6:0] own_addr_q;
  logic strap_done_q;
  logic [2:0] settle_q;
  logic [7:0] rx_byte;
  logic addr_hit, ara_hit, ara_done;

  ssa_link u_link (
    .scl(scl),
    .nrst(nrst),
    .sda_i(sda_i),
    .bit_q(link_bit),
    .tog_q(link_tog)
  );

  // SCL, SDA and the bit toggle share one synchroniser so their order holds.
  ssa_sync #(.W(5)) u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .d({scl, sda_i, link_tog, strap_state}),
    .q({scl_s, sda_s, tog_s, strap_s})
  );

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      scl_p <= 1'b0;
      sda_p <= 1'b0;
      tog_p <= 1'b0;
    end else begin
      scl_p <= scl_s;
      sda_p <= sda_s;
      tog_p <= tog_s;
    end
  end

  // SCL must have been high a cycle earlier too (and SDA, for START), which
  // keeps the reset release of the synchroniser from faking a condition.
  assign start_evt = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_evt = scl_s & scl_p & ~sda_p & sda_s;
  assign bit_evt = tog_s ^ tog_p;
  assign scl_fall = scl_p & ~scl_s;
  assign rx_byte = {rx_q[6:0], link_bit};
  assign addr_hit = strap_done_q && rx_byte[7:1] == own_addr_q;
  assign ara_hit = alert_oe && rx_byte[7:1] == ARA_ADDR &&
                   rx_byte[0] == RW_READ;
  assign ara_done = bit_evt && state_q == ST_RACK && ara_q;

  // The strap is read once, a few cycles after reset, and then held.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      settle_q <= 3'h0;
      strap_done_q <= 1'b0;
      own_addr_q <= 7'h00;
    end else if (!strap_done_q) begin
      if (settle_q == STRAP_SETTLE) begin
        strap_done_q <= 1'b1;
        own_addr_q <= {ADDR_FIXED, strap_low(strap_s)};
      end else begin
        settle_q <= settle_q + 3'h1;
      end
    end
  end

  // Protocol sequencer. START and STOP outrank bit events so that a byte
  // cut short is dropped.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      cnt_q <= BIT_FIRST;
      wbyte_q <= WBYTE_PTR;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      rw_q <= 1'b0;
      ara_q <= 1'b0;
    end else if (start_evt) begin
      state_q <= ST_ADDR;
      cnt_q <= BIT_FIRST;
      ara_q <= 1'b0;
    end else if (stop_evt) begin
      state_q <= ST_IDLE;
    end else if (bit_evt) begin
      unique case (state_q)
        ST_IDLE: state_q <= ST_IDLE;
        ST_ADDR: begin
          rx_q <= rx_byte;
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == BIT_LAST) begin
            if (addr_hit || ara_hit) begin
              state_q <= ST_AACK;
              rw_q <= rx_byte[0];
              ara_q <= ara_hit && !addr_hit;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          cnt_q <= BIT_FIRST;
          wbyte_q <= WBYTE_PTR;
          if (rw_q == RW_READ) begin
            state_q <= ST_RDATA;
            // Alert response returns the own address in the top bits.
            tx_q <= ara_q ? {own_addr_q, 1'b0} : reg_rd_data;
          end else begin
            state_q <= ST_WDATA;
          end
        end
        ST_WDATA: begin
          rx_q <= rx_byte;
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == BIT_LAST) begin
            state_q <= ST_WACK;
          end
        end
        ST_WACK: begin
          state_q <= ST_WDATA;
          cnt_q <= BIT_FIRST;
          if (wbyte_q != WBYTE_EXTRA) begin
            wbyte_q <= wbyte_q + 2'h1;
          end
        end
        ST_RDATA: begin
          tx_q <= {tx_q[6:0], 1'b0};
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == BIT_LAST) begin
            state_q <= ST_RACK;
          end
        end
        ST_RACK: begin
          // Only one byte per read; further clocks read the released line.
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // The pointer survives every transfer; only a first write byte moves it.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_ptr <= 8'h00;
    end else if (bit_evt && !start_evt && !stop_evt &&
                 state_q == ST_WDATA && cnt_q == BIT_LAST &&
                 wbyte_q == WBYTE_PTR) begin
      reg_ptr <= rx_byte;
    end
  end

  // Bytes beyond the second are acknowledged but not stored.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_wr <= '0;
    end else begin
      reg_wr.stb <= bit_evt && !start_evt && !stop_evt &&
                    state_q == ST_WDATA && cnt_q == BIT_LAST &&
                    wbyte_q == WBYTE_DATA;
      reg_wr.ptr <= reg_ptr;
      reg_wr.data <= rx_byte;
    end
  end

  // SDA drive is set only on a seen falling SCL; a START or STOP, seen while SCL is high, releases it.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sda_oe <= 1'b0;
      sda_o <= 1'b0;
    end else if (start_evt || stop_evt) begin
      sda_oe <= 1'b0;
    end else if (scl_fall) begin
      sda_oe <= drive_low(state_q, tx_q[7]);
    end
  end

  // A fresh monitoring event wins over the clear by the alert response.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      alert_oe <= 1'b0;
    end else if (alert_event) begin
      alert_oe <= 1'b1;
    end else if (ara_done) begin
      alert_oe <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  property p_start;
    start_evt |=> state_q == ST_ADDR && cnt_q == BIT_FIRST && !sda_oe;
  endproperty
  a_start: assert property (p_start)
    else $error("START did not restart address matching");

  property p_stop;
    stop_evt |=> state_q == ST_IDLE && !sda_oe;
  endproperty
  a_stop: assert property (p_stop)
    else $error("STOP did not return to idle");

  property p_miss;
    bit_evt && !start_evt && !stop_evt && state_q == ST_ADDR &&
      cnt_q == BIT_LAST && !addr_hit && !ara_hit |=> state_q == ST_IDLE;
  endproperty
  a_miss: assert property (p_miss)
    else $error("Foreign address was not ignored");

  property p_ack;
    state_q == ST_AACK && scl_fall && !start_evt && !stop_evt |=> sda_oe;
  endproperty
  a_ack: assert property (p_ack)
    else $error("Address acknowledge not driven");

  property p_oe_scl;
    $rose(sda_oe) |-> !scl_s && $past(scl_fall);
  endproperty
  a_oe_scl: assert property (p_oe_scl)
    else $error("SDA driven outside the low clock phase");

  property p_strap;
    strap_done_q |=> $stable(own_addr_q) && own_addr_q[6:2] == ADDR_FIXED;
  endproperty
  a_strap: assert property (p_strap)
    else $error("Bus address moved after power-up");

  property p_wr_only_second;
    reg_wr.stb |-> $past(wbyte_q) == WBYTE_DATA && $stable(reg_ptr);
  endproperty
  a_wr_only_second: assert property (p_wr_only_second)
    else $error("Register written by a byte other than the second");

  property p_ptr;
    bit_evt && !start_evt && !stop_evt && state_q == ST_WDATA &&
      cnt_q == BIT_LAST && wbyte_q == WBYTE_PTR
      |=> reg_ptr == $past(rx_byte) && !reg_wr.stb;
  endproperty
  a_ptr: assert property (p_ptr)
    else $error("First write byte did not load the pointer");

  property p_read_dir;
    bit_evt && !start_evt && !stop_evt && state_q == ST_AACK && rw_q
      |=> state_q == ST_RDATA ##0 (state_q != ST_WDATA)[*2];
  endproperty
  a_read_dir: assert property (p_read_dir)
    else $error("Read transfer turned into a write");

  property p_alert_clr;
    ara_done && !alert_event |=> !alert_oe;
  endproperty
  a_alert_clr: assert property (p_alert_clr)
    else $error("Alert held after alert response");

  c_write: cover property (reg_wr.stb);
  c_read: cover property (state_q == ST_RACK && !ara_q);
  c_ara: cover property (ara_done);
  c_restart: cover property (start_evt && state_q == ST_WDATA);

endmodule
`default_nettype wire

// ==== ssa_pkg.sv ====
// Package for the management-bus slave port: constants, states and carriers.
// Assumes it is compiled before every other file of the port.
package ssa_pkg;

  // Fixed upper part of the bus address and the alert response address.
  localparam logic [4:0] ADDR_FIXED = 5'h0B;
  localparam logic [6:0] ARA_ADDR = 7'h0C;

  // Bit counting within a byte and the direction bit value for a read.
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic RW_READ = 1'b1;

  // Index of the data byte within a write transfer.
  localparam logic [1:0] WBYTE_PTR = 2'h0;
  localparam logic [1:0] WBYTE_DATA = 2'h1;
  localparam logic [1:0] WBYTE_EXTRA = 2'h2;

  // Clock cycles after reset release before the strap level is taken.
  localparam logic [2:0] STRAP_SETTLE = 3'h4;

  // Sensed level of the three-state strap and the low address bits it gives.
  typedef enum logic [1:0] {
    STRAP_GND = 2'h0,
    STRAP_OPEN = 2'h1,
    STRAP_VCC = 2'h2
  } ssa_strap_type;
  localparam logic [1:0] LOW_GND = 2'h0;
  localparam logic [1:0] LOW_OPEN = 2'h2;
  localparam logic [1:0] LOW_VCC = 2'h1;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_AACK = 7'h04,
    ST_WDATA = 7'h08,
    ST_WACK = 7'h10,
    ST_RDATA = 7'h20,
    ST_RACK = 7'h40
  } ssa_state_type;

  // Register write toward the register file: one-cycle strobe.
  typedef struct packed {
    logic stb;
    logic [7:0] ptr;
    logic [7:0] data;
  } ssa_wr_type;

endpackage

// ==== ssa_sync.sv ====
// Two-flop synchroniser for a group of independent level signals.
// Assumes each bit changes slowly against mclk and is read only as a level.
`timescale 1ns/100ps
`default_nettype none
module ssa_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // The first stage feeds the second stage and nothing else.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule
`default_nettype wire

// ==== ssa_link.sv ====
// Link-side sampler clocked by the bus clock itself.
// Assumes the data line is stable while the bus clock is high.
`timescale 1ns/100ps
`default_nettype none
module ssa_link (
  input wire logic scl,
  input wire logic nrst,
  input wire logic sda_i,
  output logic bit_q,
  output logic tog_q
);

  // Each rising bus clock samples one bit and flips the toggle, so the
  // other domain sees one event per bit and reads the bit while it holds.
  always_ff @(posedge scl or negedge nrst) begin
    if (!nrst) begin
      bit_q <= 1'b0;
      tog_q <= 1'b0;
    end else begin
      bit_q <= sda_i;
      tog_q <= ~tog_q;
    end
  end

endmodule
`default_nettype wire

// ==== ssa_host.sv ====
// Bus master model that drives the clock and pulls the data line low.
// Assumes a pull-up on the data wire; the bench resolves the wire level.
`timescale 1ns/100ps
`default_nettype none
module ssa_host (
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  // Both lines start released, which is the idle level of the bus.
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Data falls while the clock is high, from idle or as a repeated start.
  task automatic start();
    #16 sda_pull = 1'b0;
    #16 scl = 1'b1;
    #32 sda_pull = 1'b1;
    #32 scl = 1'b0;
  endtask

  // Data rises while the clock is high; the clock then stays high.
  task automatic stop();
    #16 sda_pull = 1'b1;
    #16 scl = 1'b1;
    #32 sda_pull = 1'b0;
    #32;
  endtask

  // Data moves only in the low phase; the wire is sampled late in the high
  // phase because the slave answers a few system clocks after the fall.
  task automatic bit_io(input logic b, output logic r);
    #16 sda_pull = !b;
    #16 scl = 1'b1;
    #30 r = sda;
    #2 scl = 1'b0;
  endtask

  // Eight bits MSB first then the acknowledge slot; a read ends with the
  // slot left high.
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ack_in, ack);
  endtask
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the management-bus slave port.
// Assumes the design files and ssa_host are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import ssa_pkg::*;
  logic mclk = 1'b0;
  // Left unset so that the first assertion in do_reset is a real falling
  // edge; an initialiser would never wake the asynchronous resets.
  logic nrst;
  logic alert_event = 1'b0;
  logic [1:0] strap_state = 2'h1;
  logic sda_o, sda_oe, alert_oe, scl, sda_pull;
  logic [7:0] reg_ptr;
  ssa_wr_type reg_wr;
  logic [7:0] regs [256];
  int failures = 0;
  int num_checks = 0;
  int nwr = 0;
  int cyc = 0;
  logic [1:0] lows [3] = '{2'h0, 2'h2, 2'h1};
  logic [6:0] own = 7'h2E;
  wire sda = !(sda_pull | (sda_oe & !sda_o));

  always #5 mclk = ~mclk;

  ssa_slave u_ssa_slave (.mclk(mclk), .nrst(nrst), .scl(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .strap_state(strap_state),
    .alert_event(alert_event), .alert_oe(alert_oe), .reg_ptr(reg_ptr),
    .reg_wr(reg_wr), .reg_rd_data(regs[reg_ptr]));
  ssa_host u_ssa_host (.scl(scl), .sda_pull(sda_pull), .sda(sda));

  // Register file beside the port; counting writes exposes dropped bytes.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (reg_wr.stb === 1'b1) begin
      regs[reg_wr.ptr] <= reg_wr.data;
      nwr <= nwr + 1;
    end
    if (cyc == 20000) begin
      failures++;
      $display("CHECK FAILED timeout expected done seen hung");
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic do_reset(input logic [1:0] s);
    #1 nrst = 1'b0;
    strap_state = s;
    repeat (5) @(posedge mclk);
    #1 nrst = 1'b1;
    repeat (12) @(posedge mclk);
  endtask

  // One addressed byte on its own, acknowledge returned.
  task automatic addr_only(input logic [7:0] a, output logic ack);
    logic [7:0] rx;
    u_ssa_host.start();
    u_ssa_host.xfer(a, 1'b1, rx, ack);
    u_ssa_host.stop();
  endtask

  task automatic t_strap();
    logic ack;
    for (int s = 0; s < 3; s++) begin
      do_reset(s[1:0]);
      for (int j = 0; j < 3; j++) begin
        addr_only({5'h0B, lows[j], 1'b0}, ack);
        chk("addr ack", {7'h0, s != j}, {7'h0, ack});
      end
    end
    do_reset(2'h1);
    #1 strap_state = 2'h0;
    addr_only({own, 1'b0}, ack);
    chk("latched ack", 8'h0, {7'h0, ack});
    addr_only({5'h0B, 2'h0, 1'b0}, ack);
    chk("late strap", 8'h1, {7'h0, ack});
    $display("test strap done");
  endtask

  // Two-byte write plus a third byte that must be acked and dropped.
  task automatic t_write();
    logic [7:0] rx;
    logic [7:0] b [4];
    logic ack;
    int n0;
    b = '{{own, 1'b0}, 8'h35, 8'hA5, 8'h77};
    n0 = nwr;
    u_ssa_host.start();
    for (int i = 0; i < 4; i++) begin
      u_ssa_host.xfer(b[i], 1'b1, rx, ack);
      chk("write ack", 8'h0, {7'h0, ack});
    end
    u_ssa_host.stop();
    chk("pointer", 8'h35, reg_ptr);
    chk("reg data", 8'hA5, regs[8'h35]);
    chk("write count", 8'h1, 8'(nwr - n0));
    chk("sda level", 8'h0, {7'h0, sda_o});
    $display("test write done");
  endtask

  // Read with no pointer write, then pointer write and repeated-start read.
  task automatic t_read();
    logic [7:0] rx;
    logic ack;
    int n0;
    addr_only({own, 1'b0}, ack);
    u_ssa_host.start();
    u_ssa_host.xfer({own, 1'b1}, 1'b1, rx, ack);
    u_ssa_host.xfer(8'hFF, 1'b1, rx, ack);
    u_ssa_host.stop();
    chk("held read", 8'hA5, rx);
    n0 = nwr;
    u_ssa_host.start();
    u_ssa_host.xfer({own, 1'b0}, 1'b1, rx, ack);
    u_ssa_host.xfer(8'h10, 1'b1, rx, ack);
    u_ssa_host.start();
    u_ssa_host.xfer({own, 1'b1}, 1'b1, rx, ack);
    u_ssa_host.xfer(8'hFF, 1'b1, rx, ack);
    u_ssa_host.stop();
    chk("byte read", 8'h10 ^ 8'h5A, rx);
    chk("no write", 8'h0, 8'(nwr - n0));
    chk("ptr only", 8'h10, reg_ptr);
    $display("test read done");
  endtask

  task automatic t_alert();
    logic [7:0] rx;
    logic ack;
    addr_only({7'h0C, 1'b1}, ack);
    chk("ara idle", 8'h1, {7'h0, ack});
    @(posedge mclk);
    #1 alert_event = 1'b1;
    @(posedge mclk);
    #1 alert_event = 1'b0;
    @(posedge mclk);
    chk("alert set", 8'h1, {7'h0, alert_oe});
    u_ssa_host.start();
    u_ssa_host.xfer({7'h0C, 1'b1}, 1'b1, rx, ack);
    chk("ara ack", 8'h0, {7'h0, ack});
    u_ssa_host.xfer(8'hFF, 1'b1, rx, ack);
    u_ssa_host.stop();
    chk("ara data", {own, 1'b0}, rx);
    chk("alert clear", 8'h0, {7'h0, alert_oe});
    $display("test alert done");
  endtask

  initial begin
    for (int i = 0; i < 256; i++) regs[i] = 8'(i) ^ 8'h5A;
    t_strap();
    t_write();
    t_read();
    t_alert();
    end_of_test();
  end
endmodule
`default_nettype wire
